// *** hdl/codec_interface_clock_select.sv ***
// Contract
// - ADC clock selector picks adc pin, PLL A, PLL B or master pin; resets 00.
// - With S/PDIF receiver active, ADC may use only adc pin or master pin.
// - Primary transmitter carrying ADC data sets ADC rate from its frame clock.
// - Else secondary transmitter carrying ADC data sets ADC rate from secondary frame clock.
// - S/PDIF transmitter alone using ADC data takes ADC rate from rate field.
// - ADC rate field encodes 128fs to 1152fs, resetting to 256fs.
// - S/PDIF transmitter selector picks one of four clocks, resetting to PLL A.
// - Receiver uses PLL A only; PLLs unusable for other functions while receiver active.
// - S/PDIF transmitter sending received data always uses PLL A.
// - S/PDIF transmitter rate follows subframe, primary or secondary receiver frame clock.
// - S/PDIF transmitter sending ADC data uses primary tx frame clock or rate field.
// - Primary receiver clocks come from host in slave, generator in master mode.
// - Primary receiver generator selector: master pin, PLL A or PLL B; resets 00.
// - Primary tx generator uses PLL A for received data, else follows ADC clock.
// - Slave mode with ADC on master pin: primary tx uses primary rx bit clock.
// - Secondary receive and transmit share one frame and bit clock.
// - Secondary generator selector picks one of four clocks, resetting to master pin.
// - Secondary transmitter carrying received data forces PLL A for its generator.
// - Otherwise with receiver powered, secondary generator may not use a PLL.
`timescale 1ns/100ps
`include "clock_select_map.svh"

module codec_interface_clock_select
  import clock_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [8:0] reg_wdata_in,
  output logic [8:0] reg_rdata_out,
  // Source clock pins
  input wire logic adc_clock_pin_in,
  input wire logic master_clock_pin_in,
  input wire logic pll_a_output_in,
  input wire logic pll_b_output_in,
  // Routing and mode state
  input wire logic spdif_rx_active_in,
  input wire logic [1:0] primary_tx_src_in,
  input wire logic [1:0] secondary_tx_src_in,
  input wire logic [1:0] spdif_tx_src_in,
  input wire logic primary_rx_master_in,
  input wire logic primary_tx_master_in,
  input wire logic secondary_master_in,
  // Selected clocks
  output logic adc_clk_out,
  output logic spdif_tx_clk_out,
  output logic primary_rx_gen_clk_out,
  output logic primary_tx_gen_clk_out,
  output logic secondary_gen_clk_out,
  // Rate and mode decisions
  output rate_src_e adc_rate_src_out,
  output logic [2:0] adc_oversample_rate_out,
  output rate_src_e spdif_tx_rate_src_out,
  output logic primary_tx_bclk_from_rx_out,
  output logic primary_rx_gen_en_out,
  output logic secondary_gen_en_out,
  output logic sel_fault_out
);

  function automatic logic pick(input logic [1:0] sel, input logic [3:0] clks);
    pick = clks[sel];
  endfunction

  function automatic logic is_pll(input logic [1:0] sel);
    is_pll = (sel == `SRC_PLL_A) || (sel == `SRC_PLL_B);
  endfunction

  // Forbidden PLL choices fall back to the master pin so the path keeps a clock
  function automatic logic [1:0] guard(input logic [1:0] sel, input logic rx_on);
    guard = (rx_on && is_pll(sel)) ? `SRC_MCLK : sel;
  endfunction

  logic [8:0] clock_source_select_ff;
  logic [8:0] primary_if_config_1_ff;
  logic [8:0] secondary_if_config_1_ff;
  logic [8:0] adc_control_1_ff;
  logic [3:0] clk_meta_ff;
  logic [3:0] clk_sync_ff;
  logic [1:0] req_sel [`MUX_COUNT];
  logic [1:0] cur_sel_ff [`MUX_COUNT];
  logic [`MUX_COUNT-1:0] mux_out_ff;
  logic [`MUX_COUNT-1:0] pending;
  logic [1:0] adc_raw;
  logic [1:0] tx_raw;
  logic [1:0] prx_raw;
  logic [1:0] sec_raw;
  logic [1:0] prx_mapped;
  logic nxt_fault;
  rate_src_e nxt_adc_rate_src;
  rate_src_e nxt_tx_rate_src;

  // Register writes
  // Selector and ADC rate register storage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clock_source_select_ff <= `RST_CLOCK_SOURCE_SELECT;
      primary_if_config_1_ff <= `RST_PRIMARY_IF_CONFIG_1;
      secondary_if_config_1_ff <= `RST_SECONDARY_IF_CONFIG_1;
      adc_control_1_ff <= `RST_ADC_CONTROL_1;
    end else if (reg_wr_en_in) begin
      case (reg_addr_in)
        `REG_CLOCK_SOURCE_SELECT: clock_source_select_ff <= reg_wdata_in;
        `REG_PRIMARY_IF_CONFIG_1: primary_if_config_1_ff <= reg_wdata_in;
        `REG_SECONDARY_IF_CONFIG_1: secondary_if_config_1_ff <= reg_wdata_in;
        `REG_ADC_CONTROL_1: adc_control_1_ff <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Registered read; unmapped indices return zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 9'h000;
    end else if (reg_rd_en_in) begin
      case (reg_addr_in)
        `REG_CLOCK_SOURCE_SELECT: reg_rdata_out <= clock_source_select_ff;
        `REG_PRIMARY_IF_CONFIG_1: reg_rdata_out <= primary_if_config_1_ff;
        `REG_SECONDARY_IF_CONFIG_1: reg_rdata_out <= secondary_if_config_1_ff;
        `REG_ADC_CONTROL_1: reg_rdata_out <= adc_control_1_ff;
        `REG_CLOCK_STATUS: reg_rdata_out <= {1'b0, pending, sel_fault_out, cur_sel_ff[`MUX_ADC]};
        default: reg_rdata_out <= 9'h000;
      endcase
    end
  end

  // Source clocks are foreign to clk_in, so two flops before any use
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_meta_ff <= 4'h0;
      clk_sync_ff <= 4'h0;
    end else begin
      clk_meta_ff <= {master_clock_pin_in, pll_b_output_in, pll_a_output_in, adc_clock_pin_in};
      clk_sync_ff <= clk_meta_ff;
    end
  end

  assign adc_raw = clock_source_select_ff[`ADC_SEL_MSB:`ADC_SEL_LSB];
  assign tx_raw = clock_source_select_ff[`TX_SEL_MSB:`TX_SEL_LSB];
  assign prx_raw = primary_if_config_1_ff[`PRX_SEL_MSB:`PRX_SEL_LSB];
  assign sec_raw = secondary_if_config_1_ff[`SEC_SEL_MSB:`SEC_SEL_LSB];
  // Both 00 and 11 mean the master pin
  assign prx_mapped = (prx_raw == `SRC_ADC_PIN) ? `SRC_MCLK : prx_raw;

  always_comb begin
    // ADC limited to pins while receiver active
    req_sel[`MUX_ADC] = guard(adc_raw, spdif_rx_active_in);
    // Through path forces PLL A; otherwise no PLL while receiving
    if (spdif_tx_src_in == `ROUTE_SPDIF_RX) begin
      req_sel[`MUX_SPDIF_TX] = `SRC_PLL_A;
    end else begin
      req_sel[`MUX_SPDIF_TX] = guard(tx_raw, spdif_rx_active_in);
    end
    req_sel[`MUX_PRX_MS] = guard(prx_mapped, spdif_rx_active_in);
    // Primary tx generator follows ADC unless carrying received data
    if (primary_tx_src_in == `ROUTE_SPDIF_RX) begin
      req_sel[`MUX_PTX_MS] = `SRC_PLL_A;
    end else begin
      req_sel[`MUX_PTX_MS] = req_sel[`MUX_ADC];
    end
    // PLL A for received data; pins only while receiver powered
    if (secondary_tx_src_in == `ROUTE_SPDIF_RX) begin
      req_sel[`MUX_SEC_MS] = `SRC_PLL_A;
    end else begin
      req_sel[`MUX_SEC_MS] = guard(sec_raw, spdif_rx_active_in);
    end
  end

  // Report any PLL request that had to be overridden
  assign nxt_fault = spdif_rx_active_in && (is_pll(adc_raw) || is_pll(prx_mapped)
    || (is_pll(tx_raw) && spdif_tx_src_in != `ROUTE_SPDIF_RX)
    || (is_pll(sec_raw) && secondary_tx_src_in != `ROUTE_SPDIF_RX));

  // A mux changes source only while its output and the new source are both low.
  // Limitation: a stopped new source that idles high holds the old selection.
  genvar gi;
  generate
    for (gi = 0; gi < `MUX_COUNT; gi++) begin : g_mux
      assign pending[gi] = (req_sel[gi] != cur_sel_ff[gi]);
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cur_sel_ff[gi] <= `SRC_MCLK;
          mux_out_ff[gi] <= 1'b0;
        end else if (pending[gi] && !mux_out_ff[gi] && !pick(req_sel[gi], clk_sync_ff)) begin
          cur_sel_ff[gi] <= req_sel[gi];
          mux_out_ff[gi] <= 1'b0;
        end else begin
          mux_out_ff[gi] <= pick(cur_sel_ff[gi], clk_sync_ff);
        end
      end
      // No source change unless the output was low
      glitch_free_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (cur_sel_ff[gi] != $past(cur_sel_ff[gi])) |-> ($past(mux_out_ff[gi]) == 1'b0))
        else $error("mux switched while its output was high");
      tracks_source_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!pending[gi] && !$past(pending[gi])) |-> (mux_out_ff[gi] == $past(pick(cur_sel_ff[gi], clk_sync_ff))))
        else $error("mux output does not follow the selected source");
    end
  endgenerate

  assign adc_clk_out = mux_out_ff[`MUX_ADC];
  assign spdif_tx_clk_out = mux_out_ff[`MUX_SPDIF_TX];
  assign primary_rx_gen_clk_out = mux_out_ff[`MUX_PRX_MS];
  assign primary_tx_gen_clk_out = mux_out_ff[`MUX_PTX_MS];
  assign secondary_gen_clk_out = mux_out_ff[`MUX_SEC_MS];

  always_comb begin
    // Primary tx first; then secondary; else the rate field
    if (primary_tx_src_in == `ROUTE_ADC) begin
      nxt_adc_rate_src = RS_PTX_FRAME;
    end else if (secondary_tx_src_in == `ROUTE_ADC) begin
      nxt_adc_rate_src = RS_SEC_FRAME;
    end else begin
      nxt_adc_rate_src = RS_RATE_FIELD;
    end
    // Rate from the source feeding the transmitter; ADC case
    case (spdif_tx_src_in)
      `ROUTE_SPDIF_RX: nxt_tx_rate_src = RS_SUBFRAME;
      `ROUTE_PRI_RX: nxt_tx_rate_src = RS_PRX_FRAME;
      `ROUTE_SEC_RX: nxt_tx_rate_src = RS_SEC_RX_FRAME;
      default: nxt_tx_rate_src = (primary_tx_src_in == `ROUTE_ADC) ? RS_PTX_FRAME : RS_RATE_FIELD;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      adc_rate_src_out <= RS_PTX_FRAME;
      spdif_tx_rate_src_out <= RS_SUBFRAME;
      adc_oversample_rate_out <= `RST_ADC_RATE;
      sel_fault_out <= 1'b0;
    end else begin
      adc_rate_src_out <= nxt_adc_rate_src;
      spdif_tx_rate_src_out <= nxt_tx_rate_src;
      // Ratio code passed on as programmed
      adc_oversample_rate_out <= adc_control_1_ff[`ADC_RATE_MSB:`ADC_RATE_LSB];
      sel_fault_out <= nxt_fault;
    end
  end

  // Bit clock borrowed from primary receiver; generator enables
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      primary_tx_bclk_from_rx_out <= 1'b0;
      primary_rx_gen_en_out <= 1'b0;
      secondary_gen_en_out <= 1'b0;
    end else begin
      primary_tx_bclk_from_rx_out <= !primary_tx_master_in && (req_sel[`MUX_ADC] == `SRC_MCLK);
      primary_rx_gen_en_out <= primary_rx_master_in;
      secondary_gen_en_out <= secondary_master_in;
    end
  end

  adc_pins_only_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_rx_active_in && adc_raw inside {`SRC_PLL_A, `SRC_PLL_B})
    |-> (req_sel[`MUX_ADC] == `SRC_MCLK) ##1 sel_fault_out)
    else $error("ADC requests a PLL while receiver active");
  tx_selector_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_tx_src_in != `ROUTE_SPDIF_RX && !spdif_rx_active_in) |-> (req_sel[`MUX_SPDIF_TX] == tx_raw))
    else $error("transmitter mux does not follow its selector");
  sec_selector_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (secondary_tx_src_in != `ROUTE_SPDIF_RX && !spdif_rx_active_in) |-> (req_sel[`MUX_SEC_MS] == sec_raw))
    else $error("secondary mux does not follow its selector");
  adc_rate_ptx_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (primary_tx_src_in == `ROUTE_ADC) |=> (adc_rate_src_out == RS_PTX_FRAME))
    else $error("ADC rate not from primary tx frame clock");
  adc_rate_sec_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (primary_tx_src_in != `ROUTE_ADC && secondary_tx_src_in == `ROUTE_ADC) |=> (adc_rate_src_out == RS_SEC_FRAME))
    else $error("ADC rate not from secondary frame clock");
  adc_rate_field_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_tx_src_in == `ROUTE_ADC && primary_tx_src_in != `ROUTE_ADC && secondary_tx_src_in != `ROUTE_ADC)
    |=> (adc_rate_src_out == RS_RATE_FIELD && spdif_tx_rate_src_out == RS_RATE_FIELD))
    else $error("ADC rate not from rate field");
  ratio_follows_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ##1 adc_oversample_rate_out == $past(adc_control_1_ff[`ADC_RATE_MSB:`ADC_RATE_LSB]))
    else $error("oversample ratio does not follow the field");
  through_pll_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_tx_src_in == `ROUTE_SPDIF_RX) |=> (spdif_tx_rate_src_out == RS_SUBFRAME) ##0
    ($past(req_sel[`MUX_SPDIF_TX]) == `SRC_PLL_A))
    else $error("through path not on PLL A with subframe rate");
  tx_rate_rx_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_tx_src_in == `ROUTE_PRI_RX) |=> (spdif_tx_rate_src_out == RS_PRX_FRAME))
    else $error("transmitter rate not from primary rx frame clock");
  ptx_follows_adc_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (primary_tx_src_in != `ROUTE_SPDIF_RX) |-> (req_sel[`MUX_PTX_MS] == req_sel[`MUX_ADC]))
    else $error("primary tx generator does not follow ADC clock");
  bclk_borrow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!primary_tx_master_in && adc_raw == `SRC_MCLK) |=> primary_tx_bclk_from_rx_out)
    else $error("primary tx not using primary rx bit clock");
  sec_no_pll_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (spdif_rx_active_in && secondary_tx_src_in != `ROUTE_SPDIF_RX && is_pll(sec_raw))
    |-> (req_sel[`MUX_SEC_MS] == `SRC_MCLK) ##1 sel_fault_out)
    else $error("secondary generator allowed a PLL while receiving");

endmodule // codec_interface_clock_select

// *** hdl/clock_select_map.svh ***
`ifndef CLOCK_SELECT_MAP_SVH
`define CLOCK_SELECT_MAP_SVH

// Register indices
`define REG_CLOCK_SOURCE_SELECT 7'h08
`define REG_PRIMARY_IF_CONFIG_1 7'h09
`define REG_SECONDARY_IF_CONFIG_1 7'h0b
`define REG_ADC_CONTROL_1 7'h1d
`define REG_CLOCK_STATUS 7'h7e

// Reset values
`define RST_CLOCK_SOURCE_SELECT 9'h010
`define RST_PRIMARY_IF_CONFIG_1 9'h000
`define RST_SECONDARY_IF_CONFIG_1 9'h0c0
`define RST_ADC_CONTROL_1 9'h040
`define RST_ADC_RATE 3'h2

// Field positions
`define ADC_SEL_MSB 3
`define ADC_SEL_LSB 2
`define TX_SEL_MSB 5
`define TX_SEL_LSB 4
`define PRX_SEL_MSB 7
`define PRX_SEL_LSB 6
`define SEC_SEL_MSB 7
`define SEC_SEL_LSB 6
`define ADC_RATE_MSB 7
`define ADC_RATE_LSB 5

// Common clock source codes
`define SRC_ADC_PIN 2'h0
`define SRC_PLL_A 2'h1
`define SRC_PLL_B 2'h2
`define SRC_MCLK 2'h3

// Data routing source codes
`define ROUTE_SPDIF_RX 2'h0
`define ROUTE_ADC 2'h1
`define ROUTE_SEC_RX 2'h2
`define ROUTE_PRI_RX 2'h3

// Mux indices
`define MUX_ADC 0
`define MUX_SPDIF_TX 1
`define MUX_PRX_MS 2
`define MUX_PTX_MS 3
`define MUX_SEC_MS 4
`define MUX_COUNT 5

`endif

// *** hdl/clock_select_pkg.sv ***
package clock_select_pkg;

  typedef enum logic [2:0] {
    RS_PTX_FRAME,
    RS_SEC_FRAME,
    RS_SEC_RX_FRAME,
    RS_PRX_FRAME,
    RS_SUBFRAME,
    RS_RATE_FIELD
  } rate_src_e;

endpackage

// *** sim/audio_clock_source_model.sv ***
`timescale 1ns/100ps

module audio_clock_source_model (
  // Reference clock
  input wire logic clk_in,
  // Source clocks
  output logic adc_clock_pin_out,
  output logic master_clock_pin_out,
  output logic pll_a_output_out,
  output logic pll_b_output_out
);
  logic [4:0] count_ff = 5'h00;

  // Sources run free with distinct periods, so a wrong mux pick shows
  always @(negedge clk_in) begin
    count_ff <= count_ff + 5'h01;
  end

  assign master_clock_pin_out = count_ff[1];
  assign pll_a_output_out = count_ff[2];
  assign adc_clock_pin_out = count_ff[3];
  // Slowest source bounds how long a mux may wait before it switches
  assign pll_b_output_out = count_ff[4];
endmodule // audio_clock_source_model

// *** sim/codec_interface_clock_select_test.sv ***
`timescale 1ns/100ps
`include "clock_select_map.svh"

module codec_interface_clock_select_test
  import clock_select_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, rx_act = 1'b0, prx_m = 1'b0, ptx_m = 1'b0, sec_m = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [8:0] wdata = 9'h000;
  logic [1:0] ptx = 2'h1, stx = 2'h1, txs = 2'h1;
  logic [8:0] rdata;
  wire [3:0] src;
  logic [3:0] h0, h1, h2;
  wire [4:0] clks;
  rate_src_e adc_rs, tx_rs;
  logic [2:0] ratio;
  logic bclk_rx, prx_en, sec_en, fault, rd_seen;
  logic [8:0] exp_q [$];
  logic [31:0] seed = 32'hdee62377;
  int errors = 0;
  int comparisons = 0;

  always #12.5 clk_in = ~clk_in;

  audio_clock_source_model host (.clk_in(clk_in), .adc_clock_pin_out(src[0]), .pll_a_output_out(src[1]),
    .pll_b_output_out(src[2]), .master_clock_pin_out(src[3]));

  codec_interface_clock_select dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_en_in(wr_en),
    .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .adc_clock_pin_in(src[0]), .pll_a_output_in(src[1]), .pll_b_output_in(src[2]),
    .master_clock_pin_in(src[3]), .spdif_rx_active_in(rx_act), .primary_tx_src_in(ptx),
    .secondary_tx_src_in(stx), .spdif_tx_src_in(txs), .primary_rx_master_in(prx_m),
    .primary_tx_master_in(ptx_m), .secondary_master_in(sec_m), .adc_clk_out(clks[`MUX_ADC]),
    .spdif_tx_clk_out(clks[`MUX_SPDIF_TX]), .primary_rx_gen_clk_out(clks[`MUX_PRX_MS]),
    .primary_tx_gen_clk_out(clks[`MUX_PTX_MS]), .secondary_gen_clk_out(clks[`MUX_SEC_MS]),
    .adc_rate_src_out(adc_rs), .adc_oversample_rate_out(ratio), .spdif_tx_rate_src_out(tx_rs),
    .primary_tx_bclk_from_rx_out(bclk_rx), .primary_rx_gen_en_out(prx_en),
    .secondary_gen_en_out(sec_en), .sel_fault_out(fault));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_read(input logic [8:0] exp, input logic [8:0] got);
    chk(exp, got);
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk_in);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    @(negedge clk_in);
    rd_en = 1'b1;
    addr = a;
    exp_q.push_back(e);
    @(negedge clk_in);
    rd_en = 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Each output is the chosen source as sampled three edges earlier
  task automatic chk_clks(input logic [9:0] sel);
    settle(64);
    repeat (32) begin
      @(negedge clk_in);
      for (int m = 0; m < 5; m++) chk({8'h00, h2[sel[2*m+:2]]}, {8'h00, clks[m]});
    end
  endtask

  task automatic summarize();
    if (errors == 0 && comparisons > 0 && exp_q.size() == 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    h0 <= src;
    h1 <= h0;
    h2 <= h1;
    rd_seen <= rd_en;
  end

  // Read data lands one edge after the strobe is taken
  always @(negedge clk_in) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) chk_read(exp_q.pop_front(), rdata);
  end

  initial begin
    // About five times the expected run
    #110000;
    errors++;
    summarize();
  end

  initial begin
    logic [8:0] d;
    logic [6:0] regs [4];
    regs = '{7'h08, 7'h09, 7'h0b, 7'h1d};
    settle(10);
    rst_b_in = 1'b1;
    rd(7'h08, 9'h010);
    rd(7'h09, 9'h000);
    rd(7'h0b, 9'h0c0);
    rd(7'h1d, 9'h040);
    wr(7'h20, 9'h1ff);
    rd(7'h20, 9'h000);
    for (int i = 0; i < 12; i++) begin
      d = 9'(xs());
      wr(regs[i%4], d);
      rd(regs[i%4], d);
      wr(7'h1d, {1'b0, 3'(i % 7), 5'h00});
      settle(2);
      chk({6'h00, 3'(i % 7)}, {6'h00, ratio});
      {prx_m, sec_m} = 2'(xs());
      settle(2);
      chk({7'h00, prx_m, sec_m}, {7'h00, prx_en, sec_en});
    end
    // Secondary source runs against the transmitter source, so every rate rule is reached
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        ptx = 2'(p);
        stx = 2'(3 - s);
        txs = 2'(s);
        settle(2);
        chk(9'(p == 1 ? RS_PTX_FRAME : s == 2 ? RS_SEC_FRAME : RS_RATE_FIELD), 9'(adc_rs));
        chk(9'(s == 0 ? RS_SUBFRAME : s == 3 ? RS_PRX_FRAME : s == 2 ? RS_SEC_RX_FRAME :
          p == 1 ? RS_PTX_FRAME : RS_RATE_FIELD), 9'(tx_rs));
      end
    end
    {ptx, stx, txs} = 6'h15;
    wr(7'h08, 9'h01c);
    ptx_m = 1'b0;
    settle(2);
    chk(9'h001, {8'h00, bclk_rx});
    ptx_m = 1'b1;
    settle(2);
    chk(9'h000, {8'h00, bclk_rx});
    ptx_m = 1'b0;
    wr(7'h08, 9'h010);
    settle(2);
    chk(9'h000, {8'h00, bclk_rx});
    for (int c = 0; c < 4; c++) begin
      wr(7'h08, 9'(c * 20));
      wr(7'h09, 9'(c * 64));
      wr(7'h0b, 9'(c * 64));
      chk_clks({2'(c), 2'(c), (c == 0) ? 2'h3 : 2'(c), 2'(c), 2'(c)});
    end
    // Host runs both ports as master while they carry received data
    {ptx_m, sec_m} = 2'h3;
    {ptx, stx, txs} = 6'h00;
    chk_clks({2'h1, 2'h1, 2'h3, 2'h1, 2'h3});
    {ptx, stx, txs} = 6'h15;
    rx_act = 1'b1;
    wr(7'h08, 9'h024);
    wr(7'h09, 9'h040);
    wr(7'h0b, 9'h080);
    chk_clks({2'h3, 2'h3, 2'h3, 2'h3, 2'h3});
    chk(9'h001, {8'h00, fault});
    rd(7'h7e, 9'h007);
    wr(7'h08, 9'h000);
    wr(7'h09, 9'h000);
    wr(7'h0b, 9'h000);
    chk_clks({2'h0, 2'h0, 2'h3, 2'h0, 2'h0});
    chk(9'h000, {8'h00, fault});
    summarize();
  end
endmodule // codec_interface_clock_select_test
